// ---- shared/lcdd_regs.vh ----
// Constants for the column driver data path
`ifndef LCDD_REGS_VH
`define LCDD_REGS_VH

// Channel and group counts
`define LCDD_CH_TOTAL    309
`define LCDD_GRP_W       7
`define LCDD_GRP_FIRST   7'h01
`define LCDD_GRP_LAST    7'h67
`define LCDD_XFER_300    7'h64
`define LCDD_XFER_309    7'h67

// Groups left out in 300-output mode (channels 151 to 159)
`define LCDD_SKIP_LO     7'h33
`define LCDD_SKIP_HI     7'h35

// Channel code field layout
`define LCDD_CODE_W      6
`define LCDD_PAIR_MSB    5
`define LCDD_PAIR_LSB    3
`define LCDD_STEP_MSB    2
`define LCDD_STEP_LSB    0

// Reset values
`define LCDD_CODE_RST    6'h00
`define LCDD_FIELD_RST   3'h0
`define LCDD_GRP_RST     7'h00

`endif

// ---- src/lcdd_column_driver.v ----
// Column driver data path: enable handshake, sampling, load and code decode
`timescale 1ns/1ns
`default_nettype none
`include "lcdd_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Data flow in brief
////////////////////////////////////////////////////////////////////////////
// A line starts when the input-role enable pin is high on a sample edge
// while the sequencer idles. Each later sample edge writes one group of
// three channel codes into the sampling register, ascending or descending
// with the direction held at arming, until the line length for the held
// mode is reached; the sequencer then idles again.
// A load on any sample edge copies the sampling register into per-channel
// load slots, which also hold the decoded reference pair and step.
// Limitation: a load in mid-line copies a half-filled register, so the
// source must load only between lines.
// Everything runs on ref_clk; the sample clock is only ever an enable.
// All outputs leave flip-flops, so the panel side sees no glitches.

module lcdd_column_driver #(
    parameter CH    = `LCDD_CH_TOTAL,   // Panel output channels
    parameter CODEW = `LCDD_CODE_W      // Bits per channel code
) (
    input  wire              ref_clk,
    input  wire              srst,
    input  wire              dirSel,
    input  wire              modeSel,
    input  wire              sampleClock,
    input  wire              loadIn,
    input  wire              enableFirstIn,
    output reg               enableFirstOut,
    output reg               enableFirstOe,
    input  wire              enableSecondIn,
    output reg               enableSecondOut,
    output reg               enableSecondOe,
    input  wire [2:0]        grayBit0,
    input  wire [2:0]        grayBit1,
    input  wire [2:0]        grayBit2,
    input  wire [2:0]        grayBit3,
    input  wire [2:0]        grayBit4,
    input  wire [2:0]        grayBit5,
    output wire [CH*CODEW-1:0] panelCode,
    output wire [CH*3-1:0]   refPairSel,
    output wire [CH*3-1:0]   interpStep,
    output wire [CH-1:0]     stepDivSeven,
    output wire [CH-1:0]     chanUsed,
    output reg               busy
);

    ////////////////////////////////////////////////////////////////////////
    // Sample clock edge detect
    ////////////////////////////////////////////////////////////////////////

    reg                     sclkPrev_r;     // Sample clock one cycle ago
    wire                    sclkRise;       // One-cycle enable per rising edge

    // Hazard: a pin already high when reset drops counts as an edge, so
    // the source should park the sample clock low before release.
    // The pin is synchronous to ref_clk, so no synchroniser is needed
    always @(posedge ref_clk) begin
        if (srst) begin
            sclkPrev_r <= 1'b0;
        end else begin
            sclkPrev_r <= sampleClock;
        end
    end

    assign sclkRise = sampleClock & ~sclkPrev_r;

    ////////////////////////////////////////////////////////////////////////
    // Enable pin roles
    ////////////////////////////////////////////////////////////////////////

    wire                    enableIn;       // Whichever pin is the input now
    reg                     enOut_r;        // Cascade enable toward next stage

    // Direction high: first pin listens, second pin talks
    assign enableIn = dirSel ? enableFirstIn : enableSecondIn;

    // Out of reset exactly one pin is driven at a time; a direction change swaps both
    // enables on the same edge, so the pins never fight each other.
    // Drive values and enables registered so outputs leave flip-flops
    always @(posedge ref_clk) begin
        if (srst) begin
            enableFirstOut  <= 1'b0;
            enableFirstOe   <= 1'b0;
            enableSecondOut <= 1'b0;
            enableSecondOe  <= 1'b0;
        end else begin
            enableFirstOe   <= ~dirSel;
            enableSecondOe  <= dirSel;
            enableFirstOut  <= ~dirSel & enOut_r;
            enableSecondOut <= dirSel & enOut_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    ////////////////////////////////////////////////////////////////////////

    // Two states suffice: the group pointer and capture count say where a
    // line stands, the state only says whether one is running.
    localparam ST_STANDBY = 1'b0;           // Waiting for an enable
    localparam ST_XFER    = 1'b1;           // Capturing groups

    reg                     state_r;        // Sequencer state
    reg                     state_nxt;
    reg                     lineUp_r;       // Direction held for the line
    reg                     line300_r;      // Mode held for the line
    reg [`LCDD_GRP_W-1:0]   grp_r;          // Group being filled, 1-based
    reg [`LCDD_GRP_W-1:0]   grp_nxt;
    reg [`LCDD_GRP_W-1:0]   xferCnt_r;      // Captures done this line
    reg [`LCDD_GRP_W-1:0]   xferCnt_nxt;
    reg                     enOut_nxt;
    wire [`LCDD_GRP_W-1:0]  xferLast;       // Index of final capture
    wire                    capture;        // Grayscale capture this cycle
    wire                    armNow;         // Enable seen while in standby

    // Counter holds captures already done, so the last one sees N-1
    // Line length follows mode held at arming
    assign xferLast = (line300_r ? `LCDD_XFER_300 : `LCDD_XFER_309) - 7'h01;
    // Bus ignored outside a transfer
    assign capture  = sclkRise & (state_r == ST_XFER);
    // Enable seen in standby arms the line; ignored while busy
    assign armNow   = sclkRise & (state_r == ST_STANDBY) & enableIn;

    // Next-state and counter logic
    always @* begin
        state_nxt   = state_r;
        grp_nxt     = grp_r;
        xferCnt_nxt = xferCnt_r;
        enOut_nxt   = enOut_r;
        // Cascade enable lasts exactly one sample period
        // A set later in this block beats the clear on the same edge
        if (sclkRise) begin
            enOut_nxt = 1'b0;
        end
        case (state_r)
            ST_STANDBY: begin
                if (armNow) begin
                    // First capture happens on the following edge
                    state_nxt   = ST_XFER;
                    xferCnt_nxt = `LCDD_GRP_RST;
                    // Start group depends on direction
                    grp_nxt = dirSel ? `LCDD_GRP_FIRST : `LCDD_GRP_LAST;
                end
            end
            ST_XFER: begin
                if (capture) begin
                    xferCnt_nxt = xferCnt_r + 7'h01;
                    // Raised one period before the last capture
                    if (xferCnt_r == xferLast - 7'h01) begin
                        enOut_nxt = 1'b1;
                    end
                    if (xferCnt_r == xferLast) begin
                        state_nxt = ST_STANDBY;
                    end
                    // In 300 mode groups 51 to 53 are never visited, so
                    // 100 captures still cover every active group
                    // Step to the next group, jumping the idle block
                    if (lineUp_r) begin
                        if (line300_r && grp_r == `LCDD_SKIP_LO - 7'h01) begin
                            grp_nxt = `LCDD_SKIP_HI + 7'h01;
                        end else begin
                            grp_nxt = grp_r + 7'h01;
                        end
                    end else begin
                        if (line300_r && grp_r == `LCDD_SKIP_HI + 7'h01) begin
                            grp_nxt = `LCDD_SKIP_LO - 7'h01;
                        end else begin
                            grp_nxt = grp_r - 7'h01;
                        end
                    end
                end
            end
            default: begin
                state_nxt = ST_STANDBY;
            end
        endcase
    end

    // Sequencer registers
    always @(posedge ref_clk) begin
        if (srst) begin
            state_r   <= ST_STANDBY;
            grp_r     <= `LCDD_GRP_RST;
            xferCnt_r <= `LCDD_GRP_RST;
            enOut_r   <= 1'b0;
            lineUp_r  <= 1'b1;
            line300_r <= 1'b0;
            busy      <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            grp_r     <= grp_nxt;
            xferCnt_r <= xferCnt_nxt;
            enOut_r   <= enOut_nxt;
            // Busy from the cycle after arming through the cycle of the
            // final capture, straight from a flip-flop
            busy      <= (state_nxt == ST_XFER);
            // Pins are DC levels, but hold them per line anyway
            if (armNow) begin
                lineUp_r  <= dirSel;
                line300_r <= modeSel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampling register
    ////////////////////////////////////////////////////////////////////////

    reg  [CODEW-1:0]        sampReg [0:CH-1]; // Sampling register contents
    wire [8:0]              chBase;         // First channel of the group
    wire [CODEW-1:0]        lane0;          // Code for channel 3m-2
    wire [CODEW-1:0]        lane1;          // Code for channel 3m-1
    wire [CODEW-1:0]        lane2;          // Code for channel 3m

    // Lanes come straight off the bus with no pipeline stage, so the
    // word must stand at the same ref_clk edge as the sample edge
    // Bit five weighs 32, bit zero weighs 1
    assign lane0 = {grayBit5[0], grayBit4[0], grayBit3[0],
                    grayBit2[0], grayBit1[0], grayBit0[0]};
    assign lane1 = {grayBit5[1], grayBit4[1], grayBit3[1],
                    grayBit2[1], grayBit1[1], grayBit0[1]};
    assign lane2 = {grayBit5[2], grayBit4[2], grayBit3[2],
                    grayBit2[2], grayBit1[2], grayBit0[2]};

    // Zero-based channel index 3*(m-1)
    // Built as m + 2m so no multiplier is inferred; the largest value,
    // 306, fits well inside nine bits
    assign chBase = {2'b00, grp_r} + {1'b0, grp_r, 1'b0} - 9'h003;

    // Trade-off: clearing 309 codes at reset costs area and buys nothing,
    // since normal use loads only after a full line
    // Data only, so no reset; contents are meaningless until a line fills
    always @(posedge ref_clk) begin
        if (capture) begin
            sampReg[chBase]          <= lane0;
            sampReg[chBase + 9'h001] <= lane1;
            sampReg[chBase + 9'h002] <= lane2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Load register and code decode, one slice per channel
    ////////////////////////////////////////////////////////////////////////

    wire                    loadNow;        // Load seen on a sample edge

    // A load during a transfer copies whatever has arrived so far
    assign loadNow = sclkRise & loadIn;

    // Each slot decodes its own code when it loads, so codes and decode
    // fields change on one edge and never show a mixed state
    genvar i;
    generate
        for (i = 0; i < CH; i = i + 1) begin : gCh
            reg  [CODEW-1:0] code_r;        // Load register slot
            reg  [2:0]       pair_r;        // Reference pair, ascending
            reg  [2:0]       step_r;        // Interpolation step
            reg              div7_r;        // Lowest pair divides by seven
            reg              used_r;        // Channel active
            wire             idle300;       // Channel parked in 300 mode

            // Idle span is groups 51 to 53, zero-based channels 150 to 158
            // The live mode pin decides it at load time
            assign idle300 = modeSel && (i >= 3 * (`LCDD_SKIP_LO - 1))
                                     && (i <  3 * `LCDD_SKIP_HI);

            // All outputs change together on the same edge
            always @(posedge ref_clk) begin
                if (srst) begin
                    code_r <= `LCDD_CODE_RST;
                    pair_r <= `LCDD_FIELD_RST;
                    step_r <= `LCDD_FIELD_RST;
                    div7_r <= 1'b1;
                    used_r <= 1'b1;
                end else if (loadNow) begin
                    // Unused channels are parked at code zero
                    // Parked channels also raise the seventh-step flag
                    code_r <= idle300 ? `LCDD_CODE_RST : sampReg[i];
                    pair_r <= idle300 ? `LCDD_FIELD_RST
                                      : sampReg[i][`LCDD_PAIR_MSB:`LCDD_PAIR_LSB];
                    step_r <= idle300 ? `LCDD_FIELD_RST
                                      : sampReg[i][`LCDD_STEP_MSB:`LCDD_STEP_LSB];
                    div7_r <= idle300 ||
                              (sampReg[i][`LCDD_PAIR_MSB:`LCDD_PAIR_LSB] == 3'h0);
                    used_r <= ~idle300;
                end
            end

            // Flat buses, channel c at slice c
            assign panelCode[i*CODEW +: CODEW] = code_r;
            assign refPairSel[i*3 +: 3]        = pair_r;
            assign interpStep[i*3 +: 3]        = step_r;
            assign stepDivSeven[i]             = div7_r;
            assign chanUsed[i]                 = used_r;
        end
    endgenerate

endmodule
`default_nettype wire

// ---- tb/lcd_column_driver_data_path_test.sv ----
// Self-checking bench for the column driver data path
`timescale 1ns/1ns
`default_nettype none
module lcd_column_driver_data_path_test;
    logic             ref_clk, srst, dirSel, modeSel;
    wire logic        sampleClock, loadIn, enFirst, enSecond, fOut, fOe, sOut, sOe, busy;
    wire logic [17:0] gbus;         // Grayscale bus, lane n at [n*6+:6]
    wire logic [1853:0] panelCode;
    wire logic [926:0]  refPairSel, interpStep;
    wire logic [308:0]  stepDivSeven, chanUsed;
    wire logic        pinFirst  = fOe ? fOut : enFirst;  // Resolved enable pins
    wire logic        pinSecond = sOe ? sOut : enSecond;
    int               n_fail, tests_run, cyc;
    int               expv [0:308]; // Model code per channel
    lcdd_column_driver dut_u (.ref_clk(ref_clk), .srst(srst), .dirSel(dirSel), .modeSel(modeSel),
        .sampleClock(sampleClock), .loadIn(loadIn), .enableFirstIn(pinFirst), .enableFirstOut(fOut),
        .enableFirstOe(fOe), .enableSecondIn(pinSecond), .enableSecondOut(sOut), .enableSecondOe(sOe),
        .grayBit0({gbus[12], gbus[6], gbus[0]}), .grayBit1({gbus[13], gbus[7], gbus[1]}),
        .grayBit2({gbus[14], gbus[8], gbus[2]}), .grayBit3({gbus[15], gbus[9], gbus[3]}),
        .grayBit4({gbus[16], gbus[10], gbus[4]}), .grayBit5({gbus[17], gbus[11], gbus[5]}),
        .panelCode(panelCode), .refPairSel(refPairSel), .interpStep(interpStep),
        .stepDivSeven(stepDivSeven), .chanUsed(chanUsed), .busy(busy));
    lcdd_src_model src_u (.ref_clk(ref_clk), .dirSel(dirSel), .sampleClock(sampleClock), .loadIn(loadIn),
        .enFirst(enFirst), .enSecond(enSecond), .bus(gbus));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // One line: model fills groups in order, then all channels compared
    task automatic runLine(input logic d, input logic m);
        int q [$];
        for (int i = 1; i <= 103; i++) if (!(m && i >= 51 && i <= 53)) q.push_back(i);
        if (!d) q.reverse();
        @(negedge ref_clk);
        dirSel  = d;
        modeSel = m;
        for (int i = 0; i < q.size(); i++) begin
            src_u.words[i] = 18'($urandom);
            for (int n = 0; n < 3; n++) expv[q[i]*3-3+n] = src_u.words[i][n*6+:6];
        end
        if (m) for (int c = 150; c < 159; c++) expv[c] = 0;
        src_u.sendLine(q.size());
        for (int c = 0; c < 309; c++) begin
            chk("code", expv[c], panelCode[c*6+:6]);
            chk("pair", expv[c] >> 3, refPairSel[c*3+:3]);
            chk("step", expv[c] % 8, interpStep[c*3+:3]);
            chk("seventh", expv[c] < 8, stepDivSeven[c]);
            chk("used", !(m && c >= 150 && c < 159), chanUsed[c]);
        end
    endtask
    // Hang guard, far above four lines of traffic
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        void'($urandom(95));
        n_fail    = 0;
        tests_run = 0;
        cyc       = 0;
        srst      = 1'b1;
        dirSel    = 1'b1;
        modeSel   = 1'b0;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        for (int i = 0; i < 4; i++) runLine(i[0], i[1]);
        // Mid-run reset clears the codes and sets every used flag
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("codeRst", 0, {31'h0, |panelCode});
        chk("usedRst", 1, {31'h0, &chanUsed});
        srst = 1'b0;
        results();
    end
endmodule
`default_nettype wire

// ---- tb/lcdd_chk.sv ----
// Port checker for the column driver data path
`timescale 1ns/1ns
`default_nettype none
module lcdd_chk #(
    parameter CH    = 309, // Panel channels
    parameter CODEW = 6    // Code bits
) (
    input wire logic                ref_clk,
    input wire logic                srst,
    input wire logic                dirSel,
    input wire logic                modeSel,
    input wire logic                sampleClock,
    input wire logic                loadIn,
    input wire logic                enableFirstIn,
    input wire logic                enableSecondIn,
    input wire logic                enableFirstOut,
    input wire logic                enableSecondOut,
    input wire logic                enableFirstOe,
    input wire logic                enableSecondOe,
    input wire logic [CH*CODEW-1:0] panelCode,
    input wire logic [CH*3-1:0]     refPairSel,
    input wire logic [CH-1:0]       stepDivSeven,
    input wire logic [CH-1:0]       chanUsed,
    input wire logic                busy
);
    logic       prevS_r;   // Sample clock one cycle back
    logic       modeArm_r; // Mode latched at arming
    logic [6:0] capCnt_r;  // Captures in this line
    wire logic       sEdge = sampleClock && !prevS_r;
    wire logic       enIn  = dirSel ? enableFirstIn : enableSecondIn;
    wire logic       enOut = dirSel ? enableSecondOut : enableFirstOut;
    wire logic [6:0] nLine = modeArm_r ? 7'h64 : 7'h67;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    // Edge detect and capture count; cleared whenever idle
    always_ff @(posedge ref_clk) begin
        prevS_r   <= srst ? 1'b0 : sampleClock;
        modeArm_r <= (sEdge && enIn && !busy) ? modeSel : modeArm_r;
        capCnt_r  <= (srst || !busy) ? 7'h00 : capCnt_r + {6'h00, sEdge};
    end
    // Pin pulse: two cycles of lag, two high, then low
    sequence pinPulse;
        ##2 enOut [*2] ##1 !enOut;
    endsequence
    ////////////////////////////////////////////////////////////////
    pin_role_a: assert property ($past(!srst) |->
        enableFirstOe == !$past(dirSel) && enableSecondOe == $past(dirSel))
        else $error("enable pin directions wrong");
    arm_busy_a: assert property (sEdge && enIn && !busy |=> busy)
        else $error("arming did not start a line");
    line_len_a: assert property ($fell(busy) |-> capCnt_r == nLine)
        else $error("wrong capture count in a line");
    en_out_a: assert property (busy && sEdge && capCnt_r == nLine - 7'h02 |-> pinPulse)
        else $error("enable out pulse misplaced");
    load_only_a: assert property (!$stable(panelCode) |-> $past(sEdge && loadIn, 1))
        else $error("panel outputs changed without load");
    decode_map_a: assert property (refPairSel[2:0] == panelCode[5:3] && stepDivSeven[0] == (panelCode[5:3] == 3'h0))
        else $error("pair decode wrong");
    idle_zero_a: assert property (!chanUsed[150] |-> panelCode[150*CODEW+:9*CODEW] == '0)
        else $error("idle channels not zero");
    idle_mode_a: assert property ($past(sEdge && loadIn, 2) |-> chanUsed[158:150] == {9{!$past(modeSel, 2)}})
        else $error("idle mask does not follow mode");
endmodule
bind lcdd_column_driver lcdd_chk #(.CH(CH), .CODEW(CODEW)) chk_u (.ref_clk(ref_clk), .srst(srst), .dirSel(dirSel),
    .modeSel(modeSel), .sampleClock(sampleClock), .loadIn(loadIn), .enableFirstIn(enableFirstIn),
    .enableSecondIn(enableSecondIn), .enableFirstOut(enableFirstOut), .enableSecondOut(enableSecondOut),
    .enableFirstOe(enableFirstOe), .enableSecondOe(enableSecondOe), .panelCode(panelCode),
    .refPairSel(refPairSel),
    .stepDivSeven(stepDivSeven), .chanUsed(chanUsed), .busy(busy));
`default_nettype wire

// ---- tb/lcdd_src_model.sv ----
// Timing controller model feeding one column driver
`timescale 1ns/1ns
`default_nettype none
module lcdd_src_model (
    input  wire logic       ref_clk,
    input  wire logic       dirSel,
    output logic            sampleClock,
    output logic            loadIn,
    output logic            enFirst,
    output logic            enSecond,
    output logic [17:0]     bus  // Lanes as driven, lane n at [n*6+:6]
);
    logic [17:0] words [0:102]; // Line data, lane n at [n*6+:6]
    initial begin
        sampleClock = 1'b0;
        loadIn      = 1'b0;
        enFirst     = 1'b0;
        enSecond    = 1'b0;
        bus         = 18'h0;
    end
    // One period: low with noise, then high with the word
    task automatic period(input logic [17:0] w, input logic en, input logic ld);
        @(negedge ref_clk);
        sampleClock = 1'b0;
        bus         = 18'($urandom);
        @(negedge ref_clk);
        sampleClock = 1'b1;
        bus         = w;
        loadIn      = ld;
        enFirst     = en && dirSel;
        enSecond    = en && !dirSel;
    endtask
    // Arm, stream, idle edges with junk, load, then park the clock
    task automatic sendLine(input int n);
        period(18'($urandom), 1'b1, 1'b0);
        for (int i = 0; i < n; i++) period(words[i], 1'b0, 1'b0);
        repeat (2) period(18'($urandom), 1'b0, 1'b0);
        repeat (2) period(18'($urandom), 1'b0, 1'b1);
        @(negedge ref_clk);
        sampleClock = 1'b0;
        loadIn      = 1'b0;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire
